// ---- verilog/bds_slave_top.sv ----
/*
  Slave end of an asynchronous backplane data transfer bus: single and block
  read and write cycles, address decode, acknowledge, and the write buffer.
  Assumes all backplane inputs are already synchronous to core_clk, that the
  wired levels of data and acknowledge lines are resolved outside from the
  enables, and that local storage answers a read request within a bus timeout.
*/
// Notes on behaviour
// - A block write carries one to 256 bytes in one tenure.
// - Block transfers are each one, two or four bytes wide.
// - Block write: held address advances after each transfer.
// - Block read: held address advances after each transfer.
// - A single read moves one to four bytes.
// - Latch address and modifier at cycle start, then decide selection.
// - Read: fetch data, then drive it and acknowledge in the same cycle.
// - Odd-byte-only slave uses only the lowest byte lane.
// - Even-or-odd byte slave uses lowest or second byte lane.
// - Sixteen bit slave uses the lower sixteen data lines.
// - Thirty-two bit slave uses all thirty-two data lines.
// - Write: store data first, then acknowledge.
`timescale 1ns/1ns
`include "bds_defines.svh"

////////////////////////////////////////////////////////////////////////////////

module bds_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Filling side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // Draining side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr;
  logic [AW-1:0] rdPtr;
  logic [AW:0] count;

  wire push = inValid && inReady;
  wire pop = outValid && outReady;
  wire [AW-1:0] lastPtr = AW'(DEPTH - 1);
  wire [AW-1:0] next_wrPtr = (wrPtr == lastPtr) ? '0 : wrPtr + 1'b1;
  wire [AW-1:0] next_rdPtr = (rdPtr == lastPtr) ? '0 : rdPtr + 1'b1;

  assign inReady = (count != (AW + 1)'(DEPTH));
  assign outValid = (count != '0);
  assign outData = mem[rdPtr];

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wrPtr] <= inData;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (push) wrPtr <= next_wrPtr;
      if (pop) rdPtr <= next_rdPtr;
      count <= count + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////

module bds_slave_top import bds_pkg::*; #(
  parameter bds_cap_t CAP = BDS_CAP_D32,
  parameter logic [31:0] BASE_ADDR = `BDS_BASE_ADDR,
  parameter logic [31:0] BASE_MASK = `BDS_BASE_MASK,
  parameter int FIFO_DEPTH = `BDS_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Backplane address and control
  input wire logic [31:1] vmeAddr,
  input wire logic [5:0] vmeAm,
  input wire logic asN,
  input wire logic [1:0] dsN,
  input wire logic lwordN,
  input wire logic writeN,
  input wire logic berrN,
  // Backplane data lines
  input wire logic [31:0] dataIn,
  output logic [31:0] dataOut,
  output logic dataOe,
  // Acknowledge line, open collector
  output logic dtackOut,
  output logic dtackOe,
  // Write stream to local storage
  output logic wrValid,
  input wire logic wrReady,
  output bds_wr_t wrEntry,
  // Read request to local storage
  output logic rdReq,
  output logic [31:0] rdAddr,
  output logic [3:0] rdLanes,
  input wire logic rdValid,
  input wire logic [31:0] rdData
);
  bds_state_t state;
  bds_state_t next_state;
  logic [31:0] curAddr;
  logic latWrite;
  logic latBlock;
  logic [8:0] blkCount;
  logic [8:0] latBytes;
  logic [3:0] latLanes;
  logic [31:0] wrWord;
  logic fifoInReady;

  //////////////////////////////////////////////////////////////////////////////
  // Address decode and byte lane selection.

  wire [31:0] busAddr = {vmeAddr, 1'b0};
  wire amSingle = (vmeAm == `BDS_AM_SINGLE);
  wire amBlock = (vmeAm == `BDS_AM_BLOCK);
  wire selected = ((busAddr & BASE_MASK) == BASE_ADDR) && (amSingle || amBlock);
  wire ds0 = !dsN[0];
  wire ds1 = !dsN[1];
  wire dsAny = ds0 || ds1;
  wire abort = !berrN || asN;
  wire [3:0] lwordLanes = (ds0 && ds1) ? 4'hf : (ds1 ? 4'he : 4'h7);
  wire [3:0] wordLanes = (ds0 && ds1) ? 4'h3 : (ds0 ? 4'h1 : 4'h2);
  wire [3:0] lanes = !lwordN ? lwordLanes : wordLanes;
  wire [8:0] nBytes = 9'(lanes[0]) + 9'(lanes[1]) + 9'(lanes[2]) + 9'(lanes[3]);
  wire [31:0] laneMask = {{8{lanes[3]}}, {8{lanes[2]}}, {8{lanes[1]}}, {8{lanes[0]}}};
  wire [31:0] latMask = {{8{latLanes[3]}}, {8{latLanes[2]}}, {8{latLanes[1]}}, {8{latLanes[0]}}};

  // Which lane patterns the configured data path can carry.
  wire capD32 = (CAP == BDS_CAP_D32);
  wire capD16 = (CAP == BDS_CAP_D16) && lwordN;
  wire capEo = (CAP == BDS_CAP_D08EO) && lwordN && (ds0 ^ ds1);
  wire capOdd = lwordN && ds0 && !ds1;
  wire capOk = capD32 || capD16 || capEo || capOdd;

  // Blocks never use three byte transfers and stop at the byte limit.
  wire blockOk = !latBlock || ((nBytes != `BDS_BYTES_THREE)
                 && ((blkCount + nBytes) <= `BDS_BLOCK_MAX_BYTES));
  wire accept = dsAny && capOk && blockOk;
  wire startXfer = (state == BDS_WAIT_DS) && !abort && accept;
  wire pushFire = (state == BDS_PUSH) && fifoInReady && !abort;
  wire xferDone = (state == BDS_ACK) && !abort && !dsAny;

  //////////////////////////////////////////////////////////////////////////////
  // Cycle sequencing.

  always_comb begin
    next_state = state;
    case (state)
      BDS_IDLE: begin
        if (!asN) next_state = selected ? BDS_WAIT_DS : BDS_SKIP;
      end
      BDS_SKIP: begin
        if (asN) next_state = BDS_IDLE;
      end
      BDS_WAIT_DS: begin
        if (asN) next_state = BDS_IDLE;
        else if (!berrN) next_state = BDS_SKIP;
        else if (dsAny) next_state = !accept ? BDS_SKIP : (latWrite ? BDS_PUSH : BDS_FETCH);
      end
      BDS_PUSH: begin
        if (abort) next_state = BDS_SKIP;
        else if (fifoInReady) next_state = BDS_ACK;
      end
      BDS_FETCH: begin
        if (abort) next_state = BDS_SKIP;
        else if (rdValid) next_state = BDS_ACK;
      end
      BDS_ACK: begin
        if (abort) next_state = BDS_SKIP;
        else if (!dsAny) next_state = latBlock ? BDS_WAIT_DS : BDS_SKIP;
      end
      default: next_state = BDS_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) state <= BDS_IDLE;
    else state <= next_state;
  end

  // Address and modifier are captured once; later transfers reuse them.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      curAddr <= '0;
      latWrite <= 1'b0;
      latBlock <= 1'b0;
      blkCount <= '0;
    end else if (state == BDS_IDLE && !asN) begin
      curAddr <= busAddr;
      latWrite <= !writeN;
      latBlock <= amBlock;
      blkCount <= '0;
    end else if (xferDone && latBlock) begin
      curAddr <= curAddr + 32'(latBytes);
      blkCount <= blkCount + latBytes;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      latBytes <= '0;
      latLanes <= '0;
      wrWord <= '0;
    end else if (startXfer) begin
      latBytes <= nBytes;
      latLanes <= lanes;
      wrWord <= dataIn & laneMask;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Backplane drivers and local read request.

  always_ff @(posedge core_clk) begin
    if (rst) begin
      dataOut <= '0;
      dataOe <= 1'b0;
      dtackOe <= 1'b0;
      dtackOut <= 1'b0;
      rdReq <= 1'b0;
      rdAddr <= '0;
      rdLanes <= '0;
    end else begin
      if (state == BDS_FETCH && rdValid) dataOut <= rdData & latMask;
      dataOe <= (next_state == BDS_ACK) && !latWrite;
      dtackOe <= (next_state == BDS_ACK);
      dtackOut <= 1'b0;
      rdReq <= startXfer && !latWrite;
      if (startXfer) begin
        rdAddr <= curAddr;
        rdLanes <= lanes;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Write buffer toward local storage.

  bds_fifo #(
    .WIDTH($bits(bds_wr_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_wr_fifo (
    .core_clk(core_clk),
    .rst(rst),
    .inValid((state == BDS_PUSH) && !abort),
    .inReady(fifoInReady),
    .inData({curAddr, wrWord, latLanes}),
    .outValid(wrValid),
    .outReady(wrReady),
    .outData(wrEntry)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_write_store_first: assert property ($rose(dtackOe) && latWrite |-> $past(pushFire))
    else $error("write acknowledged before data was stored");
  a_read_data_driven: assert property ($rose(dtackOe) && !latWrite |-> dataOe && $past(rdValid))
    else $error("read acknowledged without data on the lines");
  a_unselected_quiet: assert property (state == BDS_SKIP && $past(state) == BDS_SKIP |-> !dataOe && !dtackOe)
    else $error("unselected slave drives the bus");
  a_block_addr_step: assert property (xferDone && latBlock |=> curAddr == $past(curAddr) + 32'($past(latBytes)))
    else $error("block address did not advance by the transfer size");
  a_block_read_step: assert property (startXfer && latBlock && !latWrite |=> rdReq && rdAddr == $past(curAddr))
    else $error("block read fetched from a stale address");
  a_timer_abort: assert property (!berrN && state != BDS_IDLE && state != BDS_SKIP |=> state == BDS_SKIP ##1 !dtackOe)
    else $error("slave kept the cycle after bus timer termination");
  a_capture_addr: assert property (state == BDS_IDLE && !asN |=> curAddr == $past(busAddr))
    else $error("address not captured at cycle start");
  a_block_limit: assert property (blkCount <= `BDS_BLOCK_MAX_BYTES)
    else $error("block exceeded its byte limit");
  a_block_no_three: assert property (latBlock && $rose(dtackOe) |-> latBytes != `BDS_BYTES_THREE)
    else $error("block used a three byte transfer");
  a_odd_lane_only: assert property (CAP == BDS_CAP_D08O && dataOe |-> dataOut[31:8] == 24'h000000)
    else $error("odd byte slave drove upper lanes");
  a_low_two_lanes: assert property ((CAP == BDS_CAP_D08EO || CAP == BDS_CAP_D16) && dataOe |-> dataOut[31:16] == 16'h0000)
    else $error("narrow slave drove the upper half");

  c_single_write: cover property (state == BDS_PUSH && !latBlock ##1 dtackOe);
  c_single_read: cover property (rdReq ##[1:8] $rose(dtackOe));
  c_block_two: cover property (xferDone && latBlock ##[1:20] xferDone);
  c_timer_abort: cover property ((state == BDS_PUSH || state == BDS_FETCH) && !berrN);
endmodule

// ---- verilog/bds_defines.svh ----
/*
  Constants of the backplane data transfer slave: decode window,
  address modifier codes and block limits.
  Assumes it is included by its bare name wherever the values are needed.
*/
`ifndef BDS_DEFINES_SVH
`define BDS_DEFINES_SVH

// Decode window: the slave answers where (address & mask) equals base.
`define BDS_BASE_ADDR 32'h0000_0000
`define BDS_BASE_MASK 32'hffff_0000

// Address modifier codes that select single and block cycles.
`define BDS_AM_SINGLE 6'h01
`define BDS_AM_BLOCK 6'h02

// Largest block in bytes, and the transfer size a block may not use.
`define BDS_BLOCK_MAX_BYTES 9'h100
`define BDS_BYTES_THREE 9'h003

// Depth of the write buffer.
`define BDS_FIFO_DEPTH 4

`endif

// ---- verilog/bds_pkg.sv ----
/*
  Types shared by the backplane data transfer slave.
  Assumes nothing of its surroundings.
*/
package bds_pkg;

  // Data path capability of the slave.
  typedef enum logic [1:0] {
    BDS_CAP_D08O,
    BDS_CAP_D08EO,
    BDS_CAP_D16,
    BDS_CAP_D32
  } bds_cap_t;

  // Cycle state of the slave.
  typedef enum logic [2:0] {
    BDS_IDLE,
    BDS_SKIP,
    BDS_WAIT_DS,
    BDS_PUSH,
    BDS_FETCH,
    BDS_ACK
  } bds_state_t;

  // One write handed to local storage; lanes[i] marks byte lane i valid.
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
    logic [3:0] lanes;
  } bds_wr_t;

endpackage

// ---- tb/bds_master_model.sv ----
/*
  Backplane master and bus timer model facing the data transfer slave.
  Assumes acknowledge has a pull-up and released data lines float to the inverse of their last value.
*/
`timescale 1ns/1ns

module bds_master_model (
  // Clock
  input wire logic core_clk,
  // Backplane lines driven by the master and the timer
  output logic [31:1] vmeAddr,
  output logic [5:0] vmeAm,
  output logic asN,
  output logic [1:0] dsN,
  output logic lwordN,
  output logic writeN,
  output logic berrN,
  output logic [31:0] dataIn,
  // Slave answer
  input wire logic [31:0] dataOut,
  input wire logic dataOe,
  input wire logic dtackOe
);
  logic [5:0] tmr = 6'h00;
  logic [31:0] lastRd = 32'h0;

  initial begin
    {asN, dsN, lwordN, writeN} = 5'h1f;
    vmeAddr = '0;
    vmeAm = 6'h00;
    dataIn = 32'h0;
  end

  // The timer ends any transfer left unanswered for 40 cycles.
  always @(posedge core_clk) begin
    if (asN || dtackOe) tmr <= 6'h00;
    else if (tmr != 6'h28) tmr <= tmr + 6'h01;
    berrN <= !(tmr == 6'h28 && !asN);
  end

  // Address and modifier go out once and settle a cycle before the strobe.
  task automatic start(input logic [31:0] a, input logic [5:0] am, input logic wr);
    @(posedge core_clk);
    vmeAddr <= a[31:1];
    vmeAm <= am;
    writeN <= !wr;
    @(posedge core_clk);
    asN <= 1'b0;
  endtask

  task automatic xfer(input logic lw, input logic [1:0] ds, input logic [31:0] w,
                      output logic [31:0] r, output logic ok);
    int i;
    ok = 1'b0;
    r = ~lastRd;
    @(posedge core_clk);
    lwordN <= lw;
    dsN <= ds;
    dataIn <= w;
    for (i = 0; i < 60 && !ok && berrN; i++) begin
      @(posedge core_clk);
      if (dtackOe) begin
        ok = 1'b1;
        r = dataOe ? dataOut : ~lastRd;
      end
    end
    dsN <= 2'h3;
    dataIn <= ~w;
    for (i = 0; i < 10 && dtackOe; i++) @(posedge core_clk);
    // A transfer that neither got an answer nor was ended by the timer, or an acknowledge that never drops.
    if (dtackOe || (!ok && berrN)) begin
      testbench.n_mismatch++;
      $display("wrong value transfer end expected 0 seen 1");
    end
    lastRd = r;
  endtask

  // The bus is given up only here, after the last transfer of a single or block cycle.
  task automatic stop();
    @(posedge core_clk);
    asN <= 1'b1;
    @(posedge core_clk);
  endtask
endmodule

// ---- tb/testbench.sv ----
/*
  Self-checking bench of the data transfer slave with a storage model.
  Assumes the master model file is compiled first.
*/
`timescale 1ns/1ns
`include "bds_defines.svh"

module testbench;
  import bds_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [31:1] vmeAddr;
  logic [5:0] vmeAm, am;
  logic asN, lwordN, writeN, berrN, dataOe, dtackOut, dtackOe, wrValid, rdReq, rdValid, ok, stall, wrReady;
  logic [1:0] dsN;
  logic [31:0] dataIn, dataOut, rdAddr, rdData, r, a, lm, dataOut16, dataOut8;
  logic [3:0] rdLanes;
  bds_wr_t wrEntry;
  logic [31:0] mem [0:63];
  logic [31:0] expw [0:63];
  int n_mismatch = 0;
  int n_checks = 0;

  initial forever #20 core_clk = ~core_clk;

  bds_slave_top i_dut (.core_clk(core_clk), .rst(rst), .vmeAddr(vmeAddr), .vmeAm(vmeAm), .asN(asN),
    .dsN(dsN), .lwordN(lwordN), .writeN(writeN), .berrN(berrN), .dataIn(dataIn), .dataOut(dataOut),
    .dataOe(dataOe), .dtackOut(dtackOut), .dtackOe(dtackOe), .wrValid(wrValid), .wrReady(wrReady),
    .wrEntry(wrEntry), .rdReq(rdReq), .rdAddr(rdAddr), .rdLanes(rdLanes), .rdValid(rdValid), .rdData(rdData));

  // Narrow data paths watch the same bus and share the storage answers of the main slave.
  bds_slave_top #(.CAP(BDS_CAP_D16)) i_dut_w16 (.core_clk(core_clk), .rst(rst), .vmeAddr(vmeAddr), .vmeAm(vmeAm),
    .asN(asN), .dsN(dsN), .lwordN(lwordN), .writeN(writeN), .berrN(berrN), .dataIn(dataIn), .dataOut(dataOut16),
    .dataOe(), .dtackOut(), .dtackOe(), .wrValid(), .wrReady(wrReady), .wrEntry(), .rdReq(), .rdAddr(),
    .rdLanes(), .rdValid(rdValid), .rdData(rdData));

  bds_slave_top #(.CAP(BDS_CAP_D08O)) i_dut_w8 (.core_clk(core_clk), .rst(rst), .vmeAddr(vmeAddr), .vmeAm(vmeAm),
    .asN(asN), .dsN(dsN), .lwordN(lwordN), .writeN(writeN), .berrN(berrN), .dataIn(dataIn), .dataOut(dataOut8),
    .dataOe(), .dtackOut(), .dtackOe(), .wrValid(), .wrReady(wrReady), .wrEntry(), .rdReq(), .rdAddr(),
    .rdLanes(), .rdValid(rdValid), .rdData(rdData));

  bds_master_model m (.core_clk(core_clk), .vmeAddr(vmeAddr), .vmeAm(vmeAm), .asN(asN), .dsN(dsN),
    .lwordN(lwordN), .writeN(writeN), .berrN(berrN), .dataIn(dataIn), .dataOut(dataOut),
    .dataOe(dataOe), .dtackOe(dtackOe));

  // Storage takes buffered writes at random and answers reads one cycle after the request.
  always @(posedge core_clk) begin
    wrReady <= !stall && ($urandom % 3 != 0);
    rdValid <= rdReq;
    rdData <= mem[rdAddr[7:2]];
    if (wrValid && wrReady) mem[wrEntry.addr[7:2]] <= wrEntry.data;
  end

  function automatic logic [31:0] lane_mask(input logic lw, input logic [1:0] ds);
    logic [3:0] l;
    if (!lw) l = (ds == 2'h0) ? 4'hf : (ds == 2'h1) ? 4'he : 4'h7;
    else l = {2'h0, !ds[1], !ds[0]};
    return {{8{l[3]}}, {8{l[2]}}, {8{l[1]}}, {8{l[0]}}};
  endfunction

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic drain();
    int i;
    for (i = 0; i < 200 && wrValid !== 1'b0; i++) @(posedge core_clk);
    check("buffer drained", 32'h0, {31'h0, wrValid});
  endtask

  task automatic single(input logic [31:0] ad, input logic [5:0] md, input logic wr, input logic lw,
                        input logic [1:0] ds, input logic [31:0] w);
    m.start(ad, md, wr);
    m.xfer(lw, ds, w, r, ok);
    m.stop();
  endtask

  initial begin
    #3000000;
    n_mismatch++;
    end_sim();
  end

  initial begin
    int i;
    stall = 1'b0;
    void'($urandom(32'ha219));
    for (i = 0; i < 64; i++) begin
      mem[i] = 32'h0;
      expw[i] = $urandom;
    end
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    // Full 256-byte block with the storage stalled at first; one word more is refused.
    m.start(32'h0, `BDS_AM_BLOCK, 1'b1);
    for (i = 0; i < 65; i++) begin
      stall <= (i < 4);
      if (i == 4) check("stalled storage", 32'h0, mem[0]);
      m.xfer(1'b0, 2'h0, expw[i[5:0]], r, ok);
      check("block write ack", 32'(i < 64), {31'h0, ok});
    end
    m.stop();
    drain();
    for (i = 0; i < 64; i++) check("block write data", expw[i], mem[i]);
    m.start(32'h0, `BDS_AM_BLOCK, 1'b0);
    for (i = 0; i < 64; i++) begin
      m.xfer(1'b0, 2'h0, $urandom, r, ok);
      check("block read data", expw[i], r);
    end
    m.stop();
    // Four lane patterns of a single read: all four lanes, the low two lanes, then lane 1 alone and lane 0 alone.
    for (i = 0; i < 4; i++) begin
      lm = lane_mask(i != 0, 2'(i == 0 ? 0 : i - 1));
      single(32'h10, `BDS_AM_SINGLE, 1'b0, i != 0, 2'(i == 0 ? 0 : i - 1), 32'h0);
      check("lane read", expw[4] & lm, r);
      check("read lanes", {28'h0, lm[24], lm[16], lm[8], lm[0]}, {28'h0, rdLanes});
      check("ack level", 32'h0, {31'h0, dtackOut});
      if (i != 0) check("narrow lane read", expw[4] & lm, dataOut16);
      if (i == 3) check("odd lane read", expw[4] & 32'h0000_00ff, dataOut8);
    end
    // Random single writes read back.
    for (i = 0; i < 6; i++) begin
      a = {24'h0, 6'($urandom), 2'h0};
      expw[a[7:2]] = $urandom;
      single(a, `BDS_AM_SINGLE, 1'b1, 1'b0, 2'h0, expw[a[7:2]]);
      drain();
      single(a, `BDS_AM_SINGLE, 1'b0, 1'b0, 2'h0, 32'h0);
      check("single read", expw[a[7:2]], r);
    end
    // Storage stalled for the whole block: four writes fill the buffer, the fifth is ended by the timer and dropped.
    stall <= 1'b1;
    m.start(32'h0, `BDS_AM_BLOCK, 1'b1);
    for (i = 0; i < 5; i++) begin
      if (i < 4) expw[i[5:0]] = $urandom;
      m.xfer(1'b0, 2'h0, (i < 4) ? expw[i[5:0]] : ~expw[4], r, ok);
      check("stalled block ack", 32'(i < 4), {31'h0, ok});
    end
    m.stop();
    stall <= 1'b0;
    drain();
    check("stalled block word", expw[3], mem[3]);
    check("dropped block word", expw[4], mem[4]);
    // Foreign address, then a foreign modifier: no answer, the timer ends the cycle.
    for (i = 0; i < 2; i++) begin
      am = (i == 0) ? `BDS_AM_SINGLE : 6'h3f;
      single((i == 0) ? 32'h0001_0000 : 32'h20, am, 1'b0, 1'b0, 2'h0, 32'h0);
      check("unselected ack", 32'h0, {31'h0, ok});
    end
    // Three bytes inside a block are refused; after the timer a fresh block starts at its own address.
    m.start(32'h40, `BDS_AM_BLOCK, 1'b1);
    m.xfer(1'b0, 2'h0, 32'h5a5a_a5a5, r, ok);
    m.xfer(1'b0, 2'h1, 32'h1234_5678, r, ok);
    check("three byte block", 32'h0, {31'h0, ok});
    m.stop();
    drain();
    single(32'h80, `BDS_AM_BLOCK, 1'b0, 1'b0, 2'h0, 32'h0);
    check("block after timeout", expw[32], r);
    check("aborted block word", 32'h5a5a_a5a5, mem[16]);
    end_sim();
  end
endmodule
